/* File: hdl/cppwm_monitor.sv */
// Call-progress monitor output: registers, path attenuation and pin control
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

module cppwm_monitor
	import cppwm_pkg::*;
#(
	parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC // Cycles per 32 kHz frame
) (
	input  wire logic            sys_clk,          // 200 MHz system clock
	input  wire logic            rst_b,            // Asynchronous reset, active low
	input  wire logic [7:0]      regAddr,          // Register address
	input  wire logic [7:0]      regWrData,        // Register write data
	input  wire logic            regWrite,         // Write strobe
	input  wire logic            regRead,          // Read strobe
	output logic [7:0]           regRdData,        // Read data, cycle after strobe
	input  wire logic            sampleStrobe,     // New audio pair valid
	input  wire cppwm_audio_type audioIn,          // Receive and transmit samples
	output logic                 callProgressPin,  // Modulated monitor pin
	output logic                 callProgressPinOe // Pin driven in modulated mode
);

	logic           rstMeta_r;
	logic           rstSync_r;
	cppwm_regs_type regs_r;
	cppwm_regs_type regs_nxt;
	logic [7:0]     rdData_r;
	logic [7:0]     rdData_nxt;
	logic [15:0]    level_r;
	logic [15:0]    level_nxt;
	logic           modeActive;
	logic           modPin;
	logic signed [24:0] rxProd;
	logic signed [24:0] txProd;
	logic signed [17:0] mixSum;
	logic [CNT_W-1:0]   rzLowRun_r;
	logic [CNT_W-1:0]   rzLowRun_nxt;

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// Register writes and read mux
	always_comb begin
		regs_nxt   = regs_r;
		rdData_nxt = 8'h00;
		if (regWrite) begin
			case (regAddr)
				CTRL_ADDR: begin
					regs_nxt.modEnable = regWrData[MOD_EN_BIT];
					regs_nxt.format    = regWrData[FMT_MSB:FMT_LSB];
				end
				PINMODE_ADDR: begin
					regs_nxt.intEnable = regWrData[INT_EN_BIT];
				end
				RX_ATTEN_ADDR: begin
					regs_nxt.rxAtten = regWrData;
				end
				TX_ATTEN_ADDR: begin
					regs_nxt.txAtten = regWrData;
				end
				default: begin
					regs_nxt = regs_r;
				end
			endcase
		end
		if (regRead) begin
			case (regAddr)
				CTRL_ADDR: begin
					rdData_nxt[MOD_EN_BIT]      = regs_r.modEnable;
					rdData_nxt[FMT_MSB:FMT_LSB] = regs_r.format;
				end
				PINMODE_ADDR: begin
					rdData_nxt[INT_EN_BIT] = regs_r.intEnable;
				end
				RX_ATTEN_ADDR: begin
					rdData_nxt = regs_r.rxAtten;
				end
				TX_ATTEN_ADDR: begin
					rdData_nxt = regs_r.txAtten;
				end
				default: begin
					rdData_nxt = 8'h00; // Unmapped reads as zero
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			regs_r.modEnable <= CTRL_RST[MOD_EN_BIT];
			regs_r.format    <= CTRL_RST[FMT_MSB:FMT_LSB];
			regs_r.intEnable <= PINMODE_RST[INT_EN_BIT];
			regs_r.rxAtten   <= ATTEN_RST;
			regs_r.txAtten   <= ATTEN_RST;
			rdData_r         <= 8'h00;
		end else begin
			regs_r   <= regs_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	assign regRdData = rdData_r;

	// Linear attenuation and mix, monitor copy only; line samples never altered
	always_comb begin
		rxProd    = 25'($signed(audioIn.rx)) * 25'($signed({1'b0, regs_r.rxAtten}));
		txProd    = 25'($signed(audioIn.tx)) * 25'($signed({1'b0, regs_r.txAtten}));
		mixSum    = 18'(rxProd >>> 8) + 18'(txProd >>> 8); // Zero gain gives zero
		level_nxt = level_r;
		if (sampleStrobe) begin
			level_nxt = mixSum[16:1] ^ MID_LEVEL; // Private copy
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			level_r <= MID_LEVEL;
		end else begin
			level_r <= level_nxt;
		end
	end

	// Pin in modulated mode only with interrupt output off
	assign modeActive = regs_r.modEnable && !regs_r.intEnable;

	cppwm_modulator #(
		.PWM_PERIOD (PWM_PERIOD)
	) u_modulator (
		.sys_clk   (sys_clk),
		.rstSync_b (rstSync_r),
		.enable    (modeActive),
		.format    (regs_r.format),
		.level     (level_r),
		.pinLevel  (modPin)
	);

	assign callProgressPin   = modPin;
	assign callProgressPinOe = modeActive;

	// Low-run tally for the RZ check; a mid-level frame is never low a whole period
	always_comb begin
		rzLowRun_nxt = '0;
		if (modeActive && regs_r.format == FMT_RZ && level_r == MID_LEVEL && !callProgressPin) begin
			rzLowRun_nxt = CNT_W'(rzLowRun_r + 1'b1);
		end
	end

	always_ff @(posedge sys_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			rzLowRun_r <= '0;
		end else begin
			rzLowRun_r <= rzLowRun_nxt;
		end
	end

	// Checks
	rd_latency_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(regRead && regAddr == RX_ATTEN_ADDR) |=> (regRdData == $past(regs_r.rxAtten)))
		else $error("Receive attenuation read back wrong");

	atten_write_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(regWrite && regAddr == TX_ATTEN_ADDR) |=> (regs_r.txAtten == $past(regWrData)))
		else $error("Transmit attenuation not stored");

	format_field_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(regWrite && regAddr == CTRL_ADDR) ##1 (regRead && regAddr == CTRL_ADDR && !regWrite)
		|=> (regRdData[FMT_MSB:FMT_LSB] == $past(regWrData[FMT_MSB:FMT_LSB], 2)))
		else $error("Format field not at bits 5:4");

	full_mute_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(sampleStrobe && regs_r.rxAtten == 8'h00 && regs_r.txAtten == 8'h00) |=> (level_r == MID_LEVEL))
		else $error("Muted paths still reach monitor");

	level_hold_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		!sampleStrobe |=> $stable(level_r))
		else $error("Monitor level moved without a sample");

	int_mode_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		regs_r.intEnable |-> (!callProgressPinOe ##1 !callProgressPin))
		else $error("Pin modulated while interrupt output on");

	reserved_idle_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(modeActive && regs_r.format == FMT_RSVD) [*2] |-> !callProgressPin)
		else $error("Reserved format drives the pin");

	unmapped_zero_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(regRead && regAddr != CTRL_ADDR && regAddr != PINMODE_ADDR && regAddr != RX_ATTEN_ADDR
		&& regAddr != TX_ATTEN_ADDR) |=> (regRdData == 8'h00))
		else $error("Unmapped address read nonzero");

	rz_frame_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		rzLowRun_r < CNT_W'(PWM_PERIOD))
		else $error("RZ PWM never goes high at mid level");

	ds_mid_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(modeActive && regs_r.format == FMT_DELTA && level_r == MID_LEVEL) [*3]
		|-> (callProgressPin != $past(callProgressPin)))
		else $error("Delta-sigma stream not alternating at mid level");

	pin_idle_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		!modeActive |=> !callProgressPin)
		else $error("Pin active outside modulated mode");

	rx_write_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		(regWrite && regAddr == RX_ATTEN_ADDR) |=> (regs_r.rxAtten == $past(regWrData)))
		else $error("Receive attenuation not stored");

	rd_idle_a: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
		!regRead |=> (regRdData == 8'h00))
		else $error("Read data stands beyond its cycle");

endmodule // cppwm_monitor

/* File: hdl/cppwm_pkg.sv */
// Constants, field layout and carrier types of the call-progress monitor output
package cppwm_pkg;

	// Register map of the monitor output
	localparam logic [7:0] CTRL_ADDR     = 8'h01; // Modulator enable and output format
	localparam logic [7:0] PINMODE_ADDR  = 8'h02; // Interrupt output enable
	localparam logic [7:0] RX_ATTEN_ADDR = 8'h14; // receive_monitor_attenuation
	localparam logic [7:0] TX_ATTEN_ADDR = 8'h15; // transmit_monitor_attenuation

	// Field positions
	localparam int MOD_EN_BIT  = 3; // tone_modulator_enable in CTRL
	localparam int FMT_LSB     = 4; // tone_output_format is CTRL[5:4]
	localparam int FMT_MSB     = 5;
	localparam int INT_EN_BIT  = 0; // interrupt_output_enable in PINMODE

	// Reset values
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] PINMODE_RST = 8'h00;
	localparam logic [7:0] ATTEN_RST   = 8'h00;

	// Output format codes
	localparam logic [1:0] FMT_DELTA = 2'h0; // Delta-sigma bit stream
	localparam logic [1:0] FMT_RZ    = 2'h1; // Return-to-zero PWM
	localparam logic [1:0] FMT_BAL   = 2'h2; // Balanced (centred) PWM
	localparam logic [1:0] FMT_RSVD  = 2'h3; // Reserved, pin held low

	// Timing
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned PWM_RATE_HZ    = 32_000;
	localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_RATE_HZ; // 6250 cycles
	localparam int          CNT_W          = 13;

	// Monitor level coding
	localparam logic [15:0] MID_LEVEL = 16'h8000; // Offset-binary zero

	// Audio pair handed in from the codec path
	typedef struct packed {
		logic signed [15:0] rx; // Receive-path sample
		logic signed [15:0] tx; // Transmit-path sample
	} cppwm_audio_type;

	// Software-visible control state
	typedef struct packed {
		logic        modEnable; // tone_modulator_enable
		logic [1:0]  format;    // tone_output_format
		logic        intEnable; // interrupt_output_enable
		logic [7:0]  rxAtten;   // receive_monitor_attenuation
		logic [7:0]  txAtten;   // transmit_monitor_attenuation
	} cppwm_regs_type;

endpackage

/* File: hdl/cppwm_modulator.sv */
// Waveform generator for the call-progress pin: delta-sigma, RZ PWM, balanced PWM
`timescale 1ns/1ps
module cppwm_modulator
	import cppwm_pkg::*;
#(
	parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC
) (
	input  wire logic        sys_clk,   // System clock
	input  wire logic        rstSync_b, // Synchronised reset, active low
	input  wire logic        enable,    // Modulated output selected
	input  wire logic [1:0]  format,    // Output format code
	input  wire logic [15:0] level,     // Offset-binary monitor level
	output logic             pinLevel   // Modulated pin level
);

	localparam logic [CNT_W-1:0] PERIOD_C = CNT_W'(PWM_PERIOD);
	localparam logic [CNT_W-1:0] LAST_C   = CNT_W'(PWM_PERIOD - 1);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [15:0]      acc_r;
	logic [15:0]      acc_nxt;
	logic             pin_nxt;
	logic             dsCarry;
	logic [CNT_W-1:0] duty;
	logic [CNT_W-1:0] edgeLow;
	logic [CNT_W-1:0] edgeHigh;
	logic [28:0]      dutyProd;

	// Next period count, accumulator and pin level
	always_comb begin
		dutyProd = {13'h0, level} * {16'h0, PERIOD_C}; // Full-width product, no truncation before the shift
		duty     = dutyProd[28:16];
		edgeLow  = CNT_W'((PERIOD_C - duty) >> 1);
		edgeHigh = CNT_W'(edgeLow + duty);
		cnt_nxt  = (cnt_r == LAST_C) ? '0 : CNT_W'(cnt_r + 1'b1);
		{dsCarry, acc_nxt} = {1'b0, acc_r} + {1'b0, level};
		case (format)
			FMT_DELTA: begin
				pin_nxt = dsCarry; // First-order delta-sigma stream
			end
			FMT_RZ: begin
				pin_nxt = (cnt_r < duty); // High for the duty, then back to zero
			end
			FMT_BAL: begin
				pin_nxt = (cnt_r >= edgeLow) && (cnt_r < edgeHigh); // Centred pulse
			end
			default: begin
				pin_nxt = 1'b0; // Reserved code idles low
			end
		endcase
		if (!enable) begin
			cnt_nxt = '0;
			acc_nxt = '0;
			pin_nxt = 1'b0;
		end
	end

	// State registers
	always_ff @(posedge sys_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			cnt_r    <= '0;
			acc_r    <= '0;
			pinLevel <= 1'b0;
		end else begin
			cnt_r    <= cnt_nxt;
			acc_r    <= acc_nxt;
			pinLevel <= pin_nxt;
		end
	end

endmodule // cppwm_modulator

/* File: verification/cppwm_speaker.sv */
// Speaker stage model: tallies drive cycles of the call-progress pin
`timescale 1ns/1ps
module cppwm_speaker (
	input  wire logic sys_clk, // System clock
	input  wire logic pin,     // Call-progress pin level
	input  wire logic listen,  // Tally window open
	output int        hiCnt    // High cycles seen in window
);
	// Transistor base follows the pin; count energy per window
	always_ff @(posedge sys_clk) begin
		if (!listen) begin
			hiCnt <= 0;
		end else if (pin === 1'b1) begin
			hiCnt <= hiCnt + 1;
		end
	end
endmodule // cppwm_speaker

/* File: verification/tb_top.sv */
// Self-checking bench of the call-progress monitor output
`timescale 1ns/1ps
module tb_top;
	import cppwm_pkg::*;
	logic            sys_clk = 0;
	logic            rst_b = 0;
	logic [7:0]      regAddr = 0;
	logic [7:0]      regWrData = 0;
	logic            regWrite = 0;
	logic            regRead = 0;
	logic [7:0]      regRdData;
	logic            sampleStrobe = 0;
	cppwm_audio_type audioIn = '0;
	logic            pin, pinOe, listen = 0;
	int              hiCnt, err_count = 0, cmp_count = 0, cyc = 0;

	always #2.5 sys_clk = ~sys_clk;

	cppwm_monitor #(.PWM_PERIOD(16)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.sampleStrobe(sampleStrobe), .audioIn(audioIn), .callProgressPin(pin),
		.callProgressPinOe(pinOe));
	cppwm_speaker u_spk (.sys_clk(sys_clk), .pin(pin), .listen(listen), .hiCnt(hiCnt));

	// Compare and tally
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk(16'(regRdData), 16'(e));
	endtask

	// Pin high cycles over one 16-cycle frame
	task automatic hear(output int h);
		@(posedge sys_clk);
		listen <= 1'b1;
		repeat (16) @(posedge sys_clk);
		listen <= 1'b0;
		#1 h = hiCnt;
	endtask

	// Reference level: linear gain atten/256 per path, offset binary
	function automatic int lvl(int rx, int tx, int ra, int rb);
		int s;
		s = ((rx * ra) >>> 8) + ((tx * rb) >>> 8);
		return ((s >>> 1) & 16'hffff) ^ 16'h8000;
	endfunction

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	initial begin
		int h, e, lv, ra, rb;
		logic signed [15:0] rx, tx;
		void'($urandom(83369));
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(CTRL_ADDR, 8'h00);
		rd(PINMODE_ADDR, 8'h00);
		rd(RX_ATTEN_ADDR, 8'h00);
		rd(TX_ATTEN_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'hff);
		rd(CTRL_ADDR, 8'h38);
		// Write then read back to back, no gap
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= CTRL_ADDR;
		regWrData <= 8'h1c;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk(16'(regRdData), 16'h0018);
		wr(PINMODE_ADDR, 8'hff);
		rd(PINMODE_ADDR, 8'h01);
		wr(8'h33, 8'hff);
		rd(8'h33, 8'h00);
		hear(h);
		chk(16'(pinOe), 16'h0);
		chk(16'(h), 16'h0);
		wr(PINMODE_ADDR, 8'h00);
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 4; k++) begin
				ra = (k == 0 || k == 3) ? 0 : $urandom_range(255);
				rb = (k == 1 || k == 3) ? 0 : $urandom_range(255);
				rx = 16'($urandom());
				tx = 16'($urandom());
				wr(RX_ATTEN_ADDR, 8'(ra));
				wr(TX_ATTEN_ADDR, 8'(rb));
				wr(CTRL_ADDR, 8'h08 | 8'(f << 4));
				rd(RX_ATTEN_ADDR, 8'(ra));
				rd(TX_ATTEN_ADDR, 8'(rb));
				@(posedge sys_clk);
				sampleStrobe <= 1'b1;
				audioIn <= {rx, tx};
				@(posedge sys_clk);
				sampleStrobe <= 1'b0;
				repeat (40) @(posedge sys_clk);
				hear(h);
				lv = lvl(int'(rx), int'(tx), ra, rb);
				e = (f == 3) ? 0 : (lv >> 12);
				if (f == 0 && (h == e + 1 || h + 1 == e)) e = h;
				chk(16'(pinOe), 16'h1);
				chk(16'(h), 16'(e));
			end
		end
		print_verdict();
	end
endmodule // tb_top
